// *** cie_pkg.sv ***
// Purpose: Shared constants for the instruction execute block.
// Assumes: 8-bit data path, 32-bit classic Wishbone register port.
// Notes: Opcodes are local codes for the execute port, not fetched encodings.
package cie_pkg;
	localparam int DATA_W = 8;
	localparam int PC_W = 11;
	localparam logic [5:0] OP_IDLE = 6'h00;
	localparam logic [5:0] OP_PRECLEAR_A = 6'h01;
	localparam logic [5:0] OP_PRECLEAR_B = 6'h02;
	localparam logic [5:0] OP_INV_MEM = 6'h03;
	localparam logic [5:0] OP_INV_WORK = 6'h04;
	localparam logic [5:0] OP_BCD_ADJ = 6'h05;
	localparam logic [5:0] OP_DEC_MEM = 6'h06;
	localparam logic [5:0] OP_DEC_WORK = 6'h07;
	localparam logic [5:0] OP_INC_MEM = 6'h08;
	localparam logic [5:0] OP_INC_WORK = 6'h09;
	localparam logic [5:0] OP_SLEEP = 6'h0a;
	localparam logic [5:0] OP_JUMP = 6'h0b;
	localparam logic [5:0] OP_MOV_M2W = 6'h0c;
	localparam logic [5:0] OP_MOV_I2W = 6'h0d;
	localparam logic [5:0] OP_MOV_W2M = 6'h0e;
	localparam logic [5:0] OP_OR_MEM_W = 6'h0f;
	localparam logic [5:0] OP_OR_IMM_W = 6'h10;
	localparam logic [5:0] OP_OR_INTO_MEM = 6'h11;
	localparam logic [5:0] OP_RET = 6'h12;
	localparam logic [5:0] OP_RET_IMM = 6'h13;
	localparam logic [5:0] OP_RET_INT = 6'h14;
	localparam logic [5:0] OP_ROL_MEM = 6'h15;
	localparam logic [5:0] OP_ROL_WORK = 6'h16;
	localparam logic [5:0] OP_ROLC_MEM = 6'h17;
	localparam logic [5:0] OP_ROLC_WORK = 6'h18;
	localparam logic [5:0] OP_ROR_MEM = 6'h19;
	localparam logic [5:0] OP_ROR_WORK = 6'h1a;
	localparam logic [5:0] OP_RORC_MEM = 6'h1b;
	localparam logic [5:0] OP_RORC_WORK = 6'h1c;
	localparam logic [5:0] OP_SUB_BORROW = 6'h1d;
	// Register word offsets (byte addresses).
	localparam logic [3:0] ADR_WORK = 4'h0;
	localparam logic [3:0] ADR_STATUS = 4'h4;
	localparam logic [3:0] ADR_PC = 4'h8;
	localparam logic [3:0] ADR_CTRL = 4'hc;
	// Status field positions.
	localparam int ST_C = 0;
	localparam int ST_HC = 1;
	localparam int ST_Z = 2;
	localparam int ST_PD = 3;
	localparam int ST_TO = 4;
	localparam int ST_GIE = 5;
	localparam int ST_SLEEP = 6;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] WORK_RST = 8'h00;
	localparam logic [3:0] BCD_LIMIT = 4'h9;
	localparam logic [3:0] BCD_FIX = 4'h6;
endpackage

// *** cie_core.sv ***
// Purpose: Execute stage for one group of 8-bit instructions.
// Assumes: One clock, asynchronous active-low reset, memory read data valid with the request.
// Notes: Software can inspect work, status and program counter over Wishbone, and preset work, program counter and the C, HC, Z and GIE status bits
// in a cycle with the clock enable high and no instruction executing or interrupt being taken.
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// RULE_01: Pre-clear B acts only when it alternates with pre-clear A.
// RULE_02: Invert memory complements the memory byte, updates only zero.
// RULE_03: Invert to work writes complement to work, memory kept, zero only.
// RULE_04: BCD adjust adds six per nibble above nine or with its carry, writes memory.
// RULE_05: BCD adjust changes only carry, set when decimal sum passes one hundred.
// RULE_06: Subtract one to memory or work, only zero changes.
// RULE_07: Add one to memory or work, only zero changes.
// RULE_08: Sleep halts, clears watchdog and prescaler, sets powerdown, clears expiry.
// RULE_09: Jump loads address field, takes two cycles, no flag changes.
// RULE_10: Copy value moves memory or immediate to work, or work to memory.
// RULE_11: Idle cycle changes nothing.
// RULE_12: OR work with memory or immediate, result to work or memory, zero only.
// RULE_13: Subroutine exit pops program counter; immediate form loads work, no flags.
// RULE_14: Interrupt exit pops counter, sets global enable; pending interrupt first.
// RULE_15: Rotate left wraps bit seven into bit zero, no flags.
// RULE_16: Rotate left through carry: old carry to bit zero, bit seven to carry.
// RULE_17: Rotate right wraps bit zero into bit seven, no flags.
// RULE_18: Rotate right through carry: old carry to bit seven, bit zero to carry.
// RULE_19: Subtract with borrow to work; carry cleared when result negative.
// RULE_20: Subtract with borrow sets carry when result is positive or zero.
// RULE_21: Expiry and powerdown clear only after both pre-clears consecutively.
// RULE_22: Zero flag set when the written eight-bit result is all zeros.
module cie_core #(
	parameter int PC_W = cie_pkg::PC_W
) (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_clk_en,
	input wire logic i_op_valid,
	input wire logic [5:0] i_op_code,
	input wire logic [7:0] i_op_imm,
	input wire logic [PC_W-1:0] i_op_addr,
	input wire logic [7:0] i_mem_rdata,
	input wire logic [PC_W-1:0] i_stack_top,
	input wire logic i_irq_pending,
	input wire logic i_wake,
	output logic o_op_ready,
	output logic o_mem_we,
	output logic [7:0] o_mem_wdata,
	output logic o_stack_pop,
	output logic o_wdt_clear,
	output logic o_irq_take,
	output logic o_sleeping,
	output logic [PC_W-1:0] o_pc,
	output logic [7:0] o_work,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [3:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack
);
	typedef enum logic [1:0] {CIE_RUN, CIE_DUMMY, CIE_SLEEP} cie_state_type;

	function automatic logic cie_is_zero(input logic [7:0] v);
		return v == 8'h00;
	endfunction

	cie_state_type state_r;
	logic [7:0] work_r;
	logic [7:0] work_nxt;
	logic [PC_W-1:0] pc_r;
	logic [PC_W-1:0] pc_nxt;
	logic c_r, hc_r, z_r, pd_r, to_r, gie_r;
	logic c_nxt, z_nxt, pd_nxt, to_nxt, gie_nxt;
	logic pre_a_last_r;
	logic pre_a_last_nxt;
	logic pending_irq_r;
	logic mem_we_nxt;
	logic [7:0] mem_wdata_nxt;
	logic stack_pop_nxt, wdt_clear_nxt, two_cycle, go_sleep;
	logic [8:0] bcd_sum;
	logic [8:0] sub_diff;
	logic [7:0] bcd_fix;
	logic wb_req, wb_wr, wb_ack_r;
	logic [31:0] wb_rd;
	logic [31:0] wb_dat_r;
	logic exec;

	assign exec = i_clk_en && state_r == CIE_RUN && i_op_valid;
	assign o_op_ready = state_r == CIE_RUN;
	assign wb_req = i_wb_cyc && i_wb_stb && !wb_ack_r;
	assign wb_wr = wb_req && i_wb_we && i_wb_sel[0];

	always_comb begin
		bcd_fix = 8'h00;
		if (work_r[3:0] > cie_pkg::BCD_LIMIT || hc_r)
			bcd_fix[3:0] = cie_pkg::BCD_FIX; // [RULE_04]
		if (work_r[7:4] > cie_pkg::BCD_LIMIT || c_r)
			bcd_fix[7:4] = cie_pkg::BCD_FIX; // [RULE_04]
		bcd_sum = {1'b0, work_r} + {1'b0, bcd_fix};
		sub_diff = {1'b0, work_r} - {1'b0, i_mem_rdata} - {8'h00, !c_r}; // [RULE_19]
	end

	always_comb begin
		work_nxt = work_r;
		pc_nxt = pc_r + PC_W'(1);
		c_nxt = c_r;
		z_nxt = z_r;
		pd_nxt = pd_r;
		to_nxt = to_r;
		gie_nxt = gie_r;
		pre_a_last_nxt = pre_a_last_r;
		mem_we_nxt = 1'b0;
		mem_wdata_nxt = 8'h00;
		stack_pop_nxt = 1'b0;
		wdt_clear_nxt = 1'b0;
		two_cycle = 1'b0;
		go_sleep = 1'b0;
		case (i_op_code)
			cie_pkg::OP_IDLE: begin
				pc_nxt = pc_r + PC_W'(1); // [RULE_11]
			end
			cie_pkg::OP_PRECLEAR_A: begin
				pre_a_last_nxt = 1'b1;
			end
			cie_pkg::OP_PRECLEAR_B: begin
				pre_a_last_nxt = 1'b0;
				if (pre_a_last_r) begin // [RULE_01] [RULE_21]
					wdt_clear_nxt = 1'b1;
					to_nxt = 1'b0;
					pd_nxt = 1'b0;
				end
			end
			cie_pkg::OP_INV_MEM: begin
				mem_we_nxt = 1'b1; // [RULE_02]
				mem_wdata_nxt = ~i_mem_rdata;
				z_nxt = cie_is_zero(~i_mem_rdata); // [RULE_22]
			end
			cie_pkg::OP_INV_WORK: begin
				work_nxt = ~i_mem_rdata; // [RULE_03]
				z_nxt = cie_is_zero(~i_mem_rdata);
			end
			cie_pkg::OP_BCD_ADJ: begin
				mem_we_nxt = 1'b1;
				mem_wdata_nxt = bcd_sum[7:0]; // [RULE_04]
				c_nxt = c_r | bcd_sum[8]; // [RULE_05]
			end
			cie_pkg::OP_DEC_MEM: begin
				mem_we_nxt = 1'b1; // [RULE_06]
				mem_wdata_nxt = i_mem_rdata - 8'h01;
				z_nxt = cie_is_zero(i_mem_rdata - 8'h01);
			end
			cie_pkg::OP_DEC_WORK: begin
				work_nxt = i_mem_rdata - 8'h01; // [RULE_06]
				z_nxt = cie_is_zero(i_mem_rdata - 8'h01);
			end
			cie_pkg::OP_INC_MEM: begin
				mem_we_nxt = 1'b1; // [RULE_07]
				mem_wdata_nxt = i_mem_rdata + 8'h01;
				z_nxt = cie_is_zero(i_mem_rdata + 8'h01);
			end
			cie_pkg::OP_INC_WORK: begin
				work_nxt = i_mem_rdata + 8'h01; // [RULE_07]
				z_nxt = cie_is_zero(i_mem_rdata + 8'h01);
			end
			cie_pkg::OP_SLEEP: begin
				go_sleep = 1'b1; // [RULE_08]
				wdt_clear_nxt = 1'b1;
				pd_nxt = 1'b1;
				to_nxt = 1'b0;
			end
			cie_pkg::OP_JUMP: begin
				pc_nxt = i_op_addr; // [RULE_09]
				two_cycle = 1'b1;
			end
			cie_pkg::OP_MOV_M2W: work_nxt = i_mem_rdata; // [RULE_10]
			cie_pkg::OP_MOV_I2W: work_nxt = i_op_imm; // [RULE_10]
			cie_pkg::OP_MOV_W2M: begin
				mem_we_nxt = 1'b1; // [RULE_10]
				mem_wdata_nxt = work_r;
			end
			cie_pkg::OP_OR_MEM_W: begin
				work_nxt = work_r | i_mem_rdata; // [RULE_12]
				z_nxt = cie_is_zero(work_r | i_mem_rdata);
			end
			cie_pkg::OP_OR_IMM_W: begin
				work_nxt = work_r | i_op_imm; // [RULE_12]
				z_nxt = cie_is_zero(work_r | i_op_imm);
			end
			cie_pkg::OP_OR_INTO_MEM: begin
				mem_we_nxt = 1'b1; // [RULE_12]
				mem_wdata_nxt = work_r | i_mem_rdata;
				z_nxt = cie_is_zero(work_r | i_mem_rdata);
			end
			cie_pkg::OP_RET, cie_pkg::OP_RET_IMM, cie_pkg::OP_RET_INT: begin
				pc_nxt = i_stack_top; // [RULE_13]
				stack_pop_nxt = 1'b1;
				two_cycle = 1'b1;
				if (i_op_code == cie_pkg::OP_RET_IMM)
					work_nxt = i_op_imm; // [RULE_13]
				if (i_op_code == cie_pkg::OP_RET_INT)
					gie_nxt = 1'b1; // [RULE_14]
			end
			cie_pkg::OP_ROL_MEM: begin
				mem_we_nxt = 1'b1; // [RULE_15]
				mem_wdata_nxt = {i_mem_rdata[6:0], i_mem_rdata[7]};
			end
			cie_pkg::OP_ROL_WORK: work_nxt = {i_mem_rdata[6:0], i_mem_rdata[7]}; // [RULE_15]
			cie_pkg::OP_ROLC_MEM: begin
				mem_we_nxt = 1'b1; // [RULE_16]
				mem_wdata_nxt = {i_mem_rdata[6:0], c_r};
				c_nxt = i_mem_rdata[7];
			end
			cie_pkg::OP_ROLC_WORK: begin
				work_nxt = {i_mem_rdata[6:0], c_r}; // [RULE_16]
				c_nxt = i_mem_rdata[7];
			end
			cie_pkg::OP_ROR_MEM: begin
				mem_we_nxt = 1'b1; // [RULE_17]
				mem_wdata_nxt = {i_mem_rdata[0], i_mem_rdata[7:1]};
			end
			cie_pkg::OP_ROR_WORK: work_nxt = {i_mem_rdata[0], i_mem_rdata[7:1]}; // [RULE_17]
			cie_pkg::OP_RORC_MEM: begin
				mem_we_nxt = 1'b1; // [RULE_18]
				mem_wdata_nxt = {c_r, i_mem_rdata[7:1]};
				c_nxt = i_mem_rdata[0];
			end
			cie_pkg::OP_RORC_WORK: begin
				work_nxt = {c_r, i_mem_rdata[7:1]}; // [RULE_18]
				c_nxt = i_mem_rdata[0];
			end
			cie_pkg::OP_SUB_BORROW: begin
				work_nxt = sub_diff[7:0]; // [RULE_19]
				c_nxt = !sub_diff[8]; // [RULE_19] [RULE_20]
				z_nxt = cie_is_zero(sub_diff[7:0]);
			end
			default: pc_nxt = pc_r + PC_W'(1);
		endcase
		// Any other opcode breaks the alternation of the two pre-clears.
		if (i_op_code != cie_pkg::OP_PRECLEAR_A && i_op_code != cie_pkg::OP_PRECLEAR_B)
			pre_a_last_nxt = 1'b0;
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_r <= CIE_RUN;
		end else if (i_clk_en) begin
			case (state_r)
				CIE_RUN: begin
					if (exec && go_sleep)
						state_r <= CIE_SLEEP; // [RULE_08]
					else if (exec && two_cycle)
						state_r <= CIE_DUMMY; // [RULE_09]
				end
				CIE_DUMMY: state_r <= CIE_RUN;
				CIE_SLEEP: if (i_wake) state_r <= CIE_RUN;
				default: state_r <= CIE_RUN;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			work_r <= cie_pkg::WORK_RST;
			pc_r <= '0;
			{gie_r, to_r, pd_r, z_r, hc_r, c_r} <= 6'h00;
			pre_a_last_r <= 1'b0;
		end else if (i_clk_en) begin
			if (exec) begin
				work_r <= work_nxt;
				pc_r <= pc_nxt;
				c_r <= c_nxt;
				z_r <= z_nxt;
				pd_r <= pd_nxt;
				to_r <= to_nxt;
				gie_r <= gie_nxt;
				pre_a_last_r <= pre_a_last_nxt;
			end else if (state_r == CIE_DUMMY && pending_irq_r) begin
				gie_r <= 1'b0; // [RULE_14]
			end else if (wb_wr) begin
				case (i_wb_adr)
					cie_pkg::ADR_WORK: work_r <= i_wb_dat[7:0];
					cie_pkg::ADR_STATUS: begin
						c_r <= i_wb_dat[cie_pkg::ST_C];
						hc_r <= i_wb_dat[cie_pkg::ST_HC];
						z_r <= i_wb_dat[cie_pkg::ST_Z];
						gie_r <= i_wb_dat[cie_pkg::ST_GIE];
					end
					cie_pkg::ADR_PC: pc_r <= i_wb_dat[PC_W-1:0];
					default: work_r <= work_r;
				endcase
			end
		end
	end

	// An interrupt pending at interrupt exit is taken in the dummy cycle, before the program resumes.
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pending_irq_r <= 1'b0;
			o_irq_take <= 1'b0;
		end else if (i_clk_en) begin
			pending_irq_r <= exec && i_op_code == cie_pkg::OP_RET_INT && i_irq_pending;
			o_irq_take <= state_r == CIE_DUMMY && pending_irq_r; // [RULE_14]
		end else begin
			o_irq_take <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_mem_we <= 1'b0;
			o_mem_wdata <= 8'h00;
			o_stack_pop <= 1'b0;
			o_wdt_clear <= 1'b0;
		end else if (i_clk_en) begin
			o_mem_we <= exec && mem_we_nxt;
			o_mem_wdata <= mem_wdata_nxt;
			o_stack_pop <= exec && stack_pop_nxt;
			o_wdt_clear <= exec && wdt_clear_nxt; // [RULE_08]
		end else begin
			o_mem_we <= 1'b0;
			o_stack_pop <= 1'b0;
			o_wdt_clear <= 1'b0;
		end
	end

	always_comb begin
		wb_rd = 32'h0000_0000;
		case (i_wb_adr)
			cie_pkg::ADR_WORK: wb_rd[7:0] = work_r;
			cie_pkg::ADR_STATUS: wb_rd[6:0] = {state_r == CIE_SLEEP, gie_r, to_r, pd_r, z_r, hc_r, c_r};
			cie_pkg::ADR_PC: wb_rd[PC_W-1:0] = pc_r;
			default: wb_rd = 32'h0000_0000;
		endcase
	end

	// Wishbone answers one cycle after the request regardless of the clock enable.
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wb_ack_r <= 1'b0;
			wb_dat_r <= 32'h0000_0000;
		end else begin
			wb_ack_r <= wb_req;
			if (wb_req)
				wb_dat_r <= wb_rd;
		end
	end

	assign o_wb_ack = wb_ack_r;
	assign o_wb_dat = wb_dat_r;
	assign o_pc = pc_r;
	assign o_work = work_r;
	assign o_sleeping = state_r == CIE_SLEEP;

	property p_preclear_b_alone;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		exec && i_op_code == cie_pkg::OP_PRECLEAR_B && !pre_a_last_r |=> !o_wdt_clear && $stable(to_r) && $stable(pd_r);
	endproperty
	a_preclear_b_alone: assert property (p_preclear_b_alone) else $error("Lone pre-clear B had effect."); // [RULE_01]

	property p_preclear_pair;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		exec && i_op_code == cie_pkg::OP_PRECLEAR_B && pre_a_last_r |=> o_wdt_clear && !to_r && !pd_r;
	endproperty
	a_preclear_pair: assert property (p_preclear_pair) else $error("Pre-clear pair did not clear."); // [RULE_21]

	property p_inv_mem;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		exec && i_op_code == cie_pkg::OP_INV_MEM |=> o_mem_we && o_mem_wdata == ~$past(i_mem_rdata) && $stable(c_r);
	endproperty
	a_inv_mem: assert property (p_inv_mem) else $error("Invert memory wrong."); // [RULE_02]

	property p_sleep;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		exec && i_op_code == cie_pkg::OP_SLEEP |=> o_sleeping && pd_r && !to_r && o_wdt_clear;
	endproperty
	a_sleep: assert property (p_sleep) else $error("Sleep did not enter power down."); // [RULE_08]

	property p_jump;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		exec && i_op_code == cie_pkg::OP_JUMP ##0 i_clk_en [*2] |-> !o_op_ready ##1 o_op_ready && o_pc == $past(i_op_addr, 2);
	endproperty
	a_jump: assert property (p_jump) else $error("Jump timing or target wrong."); // [RULE_09]

	property p_sub_carry;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		exec && i_op_code == cie_pkg::OP_SUB_BORROW |=> c_r == ($past(work_r) >= $past(i_mem_rdata) + 9'($past(!c_r)));
	endproperty
	a_sub_carry: assert property (p_sub_carry) else $error("Borrow carry wrong."); // [RULE_20]

	property p_rotc;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		exec && i_op_code == cie_pkg::OP_ROLC_WORK |=> c_r == $past(i_mem_rdata[7]) && work_r[0] == $past(c_r);
	endproperty
	a_rotc: assert property (p_rotc) else $error("Rotate through carry wrong."); // [RULE_16]

	property p_interrupt_exit;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		exec && i_op_code == cie_pkg::OP_RET_INT && !i_irq_pending |=> gie_r && o_stack_pop && o_pc == $past(i_stack_top);
	endproperty
	a_interrupt_exit: assert property (p_interrupt_exit) else $error("Interrupt exit wrong."); // [RULE_14]
endmodule

// *** cie_partner.sv ***
// Purpose: Far-side model of the addressed data byte, stack top and watchdog.
// Assumes: The byte is read combinationally and written at the edge after a write pulse.
// Notes: The bench presets mem_r and stack_r between instructions; counters tally pulses.
`timescale 1ns/1ps
module cie_partner #(
	parameter int PC_W = cie_pkg::PC_W
) (
	input wire logic i_ref_clk,
	input wire logic i_mem_we,
	input wire logic [7:0] i_mem_wdata,
	input wire logic i_stack_pop,
	input wire logic i_wdt_clear,
	input wire logic i_irq_take,
	output logic [7:0] o_mem_rdata,
	output logic [PC_W-1:0] o_stack_top
);
	logic [7:0] mem_r = 8'h00;
	logic [PC_W-1:0] stack_r = '0;
	int pops = 0;
	int clears = 0;
	int takes = 0;
	assign o_mem_rdata = mem_r;
	assign o_stack_top = stack_r;
	// Counting every high cycle catches a pulse that stands too long.
	always @(posedge i_ref_clk) begin
		if (i_mem_we === 1'b1) begin
			mem_r <= i_mem_wdata;
		end
		pops <= pops + int'(i_stack_pop === 1'b1);
		clears <= clears + int'(i_wdt_clear === 1'b1);
		takes <= takes + int'(i_irq_take === 1'b1);
	end
endmodule

// *** core_instruction_execute_test.sv ***
// Purpose: Self-checking bench comparing the execute block with a reference model.
// Assumes: One instruction at a time; registers reached over classic Wishbone.
// Notes: Flags are read back through the status register after every instruction.
`timescale 1ns/1ps
module core_instruction_execute_test;
	localparam int PW = cie_pkg::PC_W;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic clk_en = 1'b1;
	logic op_valid = 1'b0;
	logic [5:0] op_code = 6'h00;
	logic [7:0] op_imm = 8'h00;
	logic [PW-1:0] op_addr = '0;
	logic irq = 1'b0;
	logic wake = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [3:0] wb_adr = 4'h0;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0;
	logic ready, mem_we, pop, wclr, take, sleeping, ack;
	logic [7:0] mem_rdata, mem_wdata, work;
	logic [PW-1:0] stack_top, pc;
	logic [31:0] rdat;
	logic [7:0] w = 8'h00;
	logic [7:0] m = 8'h00;
	logic c, hc, z, pd, to, gie, sl;
	logic [5:0] prev = 6'h3f;
	int np = 0;
	int nc = 0;
	int nt = 0;
	int bad_count = 0;
	int checked = 0;

	cie_core i_cie_core (.i_ref_clk(clk), .i_arst_n(arst_n), .i_clk_en(clk_en), .i_op_valid(op_valid),
		.i_op_code(op_code), .i_op_imm(op_imm), .i_op_addr(op_addr), .i_mem_rdata(mem_rdata),
		.i_stack_top(stack_top), .i_irq_pending(irq), .i_wake(wake), .o_op_ready(ready), .o_mem_we(mem_we),
		.o_mem_wdata(mem_wdata), .o_stack_pop(pop), .o_wdt_clear(wclr), .o_irq_take(take),
		.o_sleeping(sleeping), .o_pc(pc), .o_work(work), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
		.i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_dat), .o_wb_dat(rdat),
		.o_wb_ack(ack));
	cie_partner i_partner (.i_ref_clk(clk), .i_mem_we(mem_we), .i_mem_wdata(mem_wdata), .i_stack_pop(pop),
		.i_wdt_clear(wclr), .i_irq_take(take), .o_mem_rdata(mem_rdata), .o_stack_top(stack_top));

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic wb(input logic we, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d,
		output logic [31:0] q);
		int n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= s;
		wb_dat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		chk(ack, 1'b1);
		q = rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge clk);
	endtask

	// The enable is dropped at random so an instruction must wait for it.
	task automatic exec(input logic [5:0] k, input logic [7:0] x, input logic [PW-1:0] a, input logic rdy);
		int n = 0;
		logic hit;
		op_valid <= 1'b1;
		op_code <= k;
		op_imm <= x;
		op_addr <= a;
		clk_en <= ($urandom % 4) != 0;
		do begin
			@(posedge clk);
			n++;
			hit = ready === 1'b1 && clk_en === 1'b1;
			clk_en <= (($urandom % 4) != 0) || hit;
		end while (!hit && n < 50);
		op_valid <= 1'b0;
		chk(hit, 1'b1);
		@(posedge clk);
		chk(ready, rdy);
		@(posedge clk);
	endtask

	task automatic model(input logic [5:0] k, input logic [7:0] x);
		logic [8:0] r;
		case (k)
			cie_pkg::OP_INV_MEM: m = ~m;
			cie_pkg::OP_INV_WORK: w = ~m;
			cie_pkg::OP_BCD_ADJ: begin
				r = {1'b0, w} + ((w[3:0] > 4'h9 || hc) ? 9'h006 : 9'h000) + ((w[7:4] > 4'h9 || c) ? 9'h060 : 9'h000);
				m = r[7:0];
				c = c | r[8];
			end
			cie_pkg::OP_DEC_MEM: m = m - 8'h01;
			cie_pkg::OP_DEC_WORK: w = m - 8'h01;
			cie_pkg::OP_INC_MEM: m = m + 8'h01;
			cie_pkg::OP_INC_WORK: w = m + 8'h01;
			cie_pkg::OP_MOV_M2W: w = m;
			cie_pkg::OP_MOV_I2W: w = x;
			cie_pkg::OP_MOV_W2M: m = w;
			cie_pkg::OP_OR_MEM_W: w = w | m;
			cie_pkg::OP_OR_IMM_W: w = w | x;
			cie_pkg::OP_OR_INTO_MEM: m = w | m;
			cie_pkg::OP_ROL_MEM: m = {m[6:0], m[7]};
			cie_pkg::OP_ROL_WORK: w = {m[6:0], m[7]};
			cie_pkg::OP_ROLC_MEM: {c, m} = {m, c};
			cie_pkg::OP_ROLC_WORK: {c, w} = {m, c};
			cie_pkg::OP_ROR_MEM: m = {m[0], m[7:1]};
			cie_pkg::OP_ROR_WORK: w = {m[0], m[7:1]};
			cie_pkg::OP_RORC_MEM: {m, c} = {c, m};
			cie_pkg::OP_RORC_WORK: {w, c} = {c, m};
			cie_pkg::OP_SUB_BORROW: begin
				r = {1'b0, w} - {1'b0, m} - {8'h00, ~c};
				w = r[7:0];
				c = ~r[8];
			end
			cie_pkg::OP_SLEEP: begin
				{pd, to, sl} = 3'b101;
				nc++;
			end
			cie_pkg::OP_PRECLEAR_B: begin
				if (prev == cie_pkg::OP_PRECLEAR_A) begin
					{pd, to} = 2'b00;
					nc++;
				end
			end
			cie_pkg::OP_RET, cie_pkg::OP_RET_IMM, cie_pkg::OP_RET_INT: begin
				np++;
				w = (k == cie_pkg::OP_RET_IMM) ? x : w;
				gie = (k == cie_pkg::OP_RET_INT) ? 1'b1 : gie;
			end
			default: ;
		endcase
		if (k inside {cie_pkg::OP_INV_MEM, cie_pkg::OP_DEC_MEM, cie_pkg::OP_INC_MEM, cie_pkg::OP_OR_INTO_MEM}) begin
			z = m == 8'h00;
		end
		if (k inside {cie_pkg::OP_INV_WORK, cie_pkg::OP_DEC_WORK, cie_pkg::OP_INC_WORK, cie_pkg::OP_OR_MEM_W,
			cie_pkg::OP_OR_IMM_W, cie_pkg::OP_SUB_BORROW}) begin
			z = w == 8'h00;
		end
		prev = k;
	endtask

	task automatic cmp(input logic [7:0] mask);
		logic [31:0] q;
		wb(1'b0, cie_pkg::ADR_WORK, 4'hf, 32'h0, q);
		chk(q, {24'h0, w});
		chk(work, w);
		wb(1'b0, cie_pkg::ADR_STATUS, 4'hf, 32'h0, q);
		chk(q & {24'h0, mask}, {25'h0, sl, gie, to, pd, z, hc, c} & {24'h0, mask});
		chk(mem_rdata, m);
		chk(i_partner.pops, np);
		chk(i_partner.clears, nc);
		chk(i_partner.takes, nt);
	endtask

	initial begin
		repeat (30000) @(posedge clk);
		bad_count++;
		final_report();
	end

	initial begin
		logic [31:0] q;
		logic [7:0] s;
		logic [5:0] k;
		logic [PW-1:0] a;
		logic [5:0] seq[9];
		void'($urandom(32'h932f2a21));
		{c, hc, z, pd, to, gie, sl} = '0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		cmp(8'h7f);
		wb(1'b0, cie_pkg::ADR_PC, 4'hf, 32'h0, q);
		chk(q, 32'h0);
		wb(1'b1, cie_pkg::ADR_CTRL, 4'hf, 32'hff, q);
		wb(1'b0, cie_pkg::ADR_CTRL, 4'hf, 32'h0, q);
		chk(q, 32'h0);
		for (int i = 0; i < 240; i++) begin
			k = (i < 30) ? i[5:0] : 6'($urandom % 30);
			if (k inside {cie_pkg::OP_PRECLEAR_A, cie_pkg::OP_PRECLEAR_B, cie_pkg::OP_SLEEP, cie_pkg::OP_JUMP,
				cie_pkg::OP_RET, cie_pkg::OP_RET_IMM, cie_pkg::OP_RET_INT}) begin
				continue;
			end
			m = 8'($urandom);
			i_partner.mem_r = m;
			s = 8'($urandom);
			wb(1'b1, cie_pkg::ADR_WORK, 4'hf, {24'h0, s}, q);
			w = s;
			s = 8'($urandom);
			// A write without the low byte lane must leave the flags alone.
			wb(1'b1, cie_pkg::ADR_STATUS, (i % 5 == 2) ? 4'he : 4'hf, {24'h0, s}, q);
			if (i % 5 != 2) begin
				{gie, z, hc, c} = {s[5], s[2:0]};
			end
			s = 8'($urandom);
			model(k, s);
			exec(k, s, '0, 1'b1);
			cmp((k == cie_pkg::OP_SUB_BORROW) ? 8'h7d : 8'h7f);
		end
		a = PW'($urandom);
		model(cie_pkg::OP_JUMP, 8'h00);
		exec(cie_pkg::OP_JUMP, 8'h00, a, 1'b0);
		chk(pc, 32'(a));
		cmp(8'h7f);
		for (int j = 0; j < 4; j++) begin
			k = (j == 0) ? cie_pkg::OP_RET : (j == 1) ? cie_pkg::OP_RET_IMM : cie_pkg::OP_RET_INT;
			a = PW'($urandom);
			i_partner.stack_r = a;
			irq <= (j == 3);
			s = 8'($urandom);
			model(k, s);
			if (j == 3) begin
				gie = 1'b0;
				nt++;
			end
			exec(k, s, '0, 1'b0);
			irq <= 1'b0;
			if (j < 3) begin
				chk(pc, 32'(a));
			end
			cmp(8'h7f);
		end
		model(cie_pkg::OP_SLEEP, 8'h00);
		exec(cie_pkg::OP_SLEEP, 8'h00, '0, 1'b0);
		chk(sleeping, 1'b1);
		cmp(8'h7f);
		wake <= 1'b1;
		for (int n = 0; n < 20 && sleeping !== 1'b0; n++) begin
			@(posedge clk);
		end
		wake <= 1'b0;
		sl = 1'b0;
		chk(sleeping, 1'b0);
		seq = '{cie_pkg::OP_PRECLEAR_B, cie_pkg::OP_PRECLEAR_A, cie_pkg::OP_PRECLEAR_A, cie_pkg::OP_IDLE,
			cie_pkg::OP_PRECLEAR_B, cie_pkg::OP_PRECLEAR_B, cie_pkg::OP_PRECLEAR_A, cie_pkg::OP_PRECLEAR_A,
			cie_pkg::OP_PRECLEAR_B};
		foreach (seq[i]) begin
			model(seq[i], 8'h00);
			exec(seq[i], 8'h00, '0, 1'b1);
			cmp(8'h7f);
		end
		final_report();
	end
endmodule
